//--- inc/fpec_pkg.sv
// package for the flash program/erase control block
// assumes an AHB-Lite slave with 32-bit data, one register per word
// ----------------------------------------------------------------
// What this block does
// - software enable write of one only accepted while write enable pin high; bit 7 mirrors pin while on-chip flash is enabled
// - setup and verify bits become one only with pin high and software enable set
// - erase mode becomes one only with pin, software enable and erase setup set
// - program mode becomes one only with pin, software enable and program setup set
// - erase verify bit one enters erase-verify mode, zero leaves it
// - program verify bit one enters program-verify mode, zero leaves it
// - error status clears to zero on reset, watchdog reset and hardware standby
// - error status reads zero when on-chip flash is disabled
// - error status is read-only; low seven bits read zero
// - flash array read during program or erase sets error flag, overlay RAM excluded
// - exception start during program or erase sets flag, listed exceptions excluded
// - sleep, standby instruction or bus release during program or erase sets flag; here only sleep and bus release set it, software standby does not
// - error flag blocks program and erase; cleared only by pin/watchdog reset, hw standby
// - erase block select clears on reset, standby, pin low or software enable zero
// - erase block bits settable only with software enable, only in modes 5 and 7
// - only blocks with their erase block bit set are erased
// - bits 0-3 map 1k blocks, bit 4 a 28k block, bits 5-7 32k blocks
// ----------------------------------------------------------------
package fpec_pkg;
	// register byte offsets
	localparam logic [7:0] FPEC_OFS_MODE = 8'h00;
	localparam logic [7:0] FPEC_OFS_ERR = 8'h04;
	localparam logic [7:0] FPEC_OFS_EBS = 8'h08;
	// mode control fields
	localparam int FPEC_B_PIN = 7;
	localparam int FPEC_B_SWE = 6;
	localparam int FPEC_B_ESU = 5;
	localparam int FPEC_B_PSU = 4;
	localparam int FPEC_B_EV = 3;
	localparam int FPEC_B_PV = 2;
	localparam int FPEC_B_E = 1;
	localparam int FPEC_B_P = 0;
	localparam int FPEC_B_ERR = 7;
	localparam logic [7:0] FPEC_RST_BYTE = 8'h00;
	localparam int FPEC_NBLK = 8;
	// flash array limits and block boundaries (byte addresses)
	localparam logic [16:0] FPEC_FLASH_TOP = 17'h1_FFFF;
	localparam logic [16:0] FPEC_BLK_BASE [0:7] = '{17'h0_0000, 17'h0_0400, 17'h0_0800,
		17'h0_0C00, 17'h0_1000, 17'h0_8000, 17'h1_0000, 17'h1_8000};
	localparam logic [16:0] FPEC_BLK_LAST [0:7] = '{17'h0_03FF, 17'h0_07FF, 17'h0_0BFF,
		17'h0_0FFF, 17'h0_7FFF, 17'h0_FFFF, 17'h1_7FFF, 17'h1_FFFF};
	localparam logic [2:0] FPEC_MODE5 = 3'h5;
	localparam logic [2:0] FPEC_MODE7 = 3'h7;
	typedef enum logic [2:0]
	{
		FPEC_ST_IDLE = 3'b001,
		FPEC_ST_ADDR = 3'b010,
		FPEC_ST_DATA = 3'b100
	} fpec_bus_e;
endpackage : fpec_pkg

//--- logic/fpec_blk_decode.sv
// erase block address decoder and erase gate
// assumes the address is a flash array byte offset
`timescale 1ns/1ns
module fpec_blk_decode
	import fpec_pkg::*;
#(
	parameter int NBLK = FPEC_NBLK
)
(
	input wire logic [NBLK-1:0] i_blk_sel,
	input wire logic [16:0] i_addr,
	output logic [NBLK-1:0] o_hit,
	output logic o_erase_ok
);
	// ----------------------------------------------------------------
	// block decode
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NBLK; g++)
		begin : g_blk
			assign o_hit[g] = (i_addr >= FPEC_BLK_BASE[g]) && (i_addr <= FPEC_BLK_LAST[g]);
		end
	endgenerate
	assign o_erase_ok = |(o_hit & i_blk_sel);
endmodule : fpec_blk_decode

//--- logic/fpec_top.sv
// flash program/erase control with AHB-Lite register access
// assumes single-word transfers and synchronous control inputs
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module fpec_top
	import fpec_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_write_enable_pin_level,
	input wire logic [2:0] i_mode_pins,
	input wire logic i_flash_enabled,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic i_watchdog_reset,
	input wire logic i_flash_read,
	input wire logic i_overlay_hit,
	input wire logic [16:0] i_flash_addr,
	input wire logic i_exc_start,
	input wire logic i_exc_exempt,
	input wire logic i_sleep_exec,
	input wire logic i_bus_release,
	output logic o_prog_active,
	output logic o_erase_active,
	output logic o_prog_verify,
	output logic o_erase_verify,
	output logic o_erase_addr_ok,
	output logic o_error_flag
);
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic wr_pend_q, wr_pend_d;
	logic [7:0] ofs_q, ofs_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] ctl_q, ctl_d;
	logic err_q, err_d;
	logic [7:0] ebs_q, ebs_d;
	logic [7:0] wbyte;
	logic take, pin, software_enable_bit, mode_ok, pe_busy;
	logic [7:0] mode_rd, err_rd;

	assign take = i_hsel && i_htrans[1] && i_hready;
	assign pin = i_write_enable_pin_level;
	assign software_enable_bit = ctl_q[FPEC_B_SWE];
	assign wbyte = i_hwdata[7:0];
	assign pe_busy = ctl_q[FPEC_B_E] || ctl_q[FPEC_B_P];
	assign mode_ok = (i_mode_pins == FPEC_MODE5) || (i_mode_pins == FPEC_MODE7);

	always_comb
	begin
		wr_pend_d = take && i_hwrite;
		ofs_d = take ? i_haddr[7:0] : ofs_q;
		rdata_d = 32'h0000_0000;
		if (take && !i_hwrite)
		begin
			case (i_haddr[7:0])
				FPEC_OFS_MODE: rdata_d = {24'h00_0000, mode_rd};
				FPEC_OFS_ERR: rdata_d = {24'h00_0000, err_rd};
				FPEC_OFS_EBS: rdata_d = {24'h00_0000, ebs_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend_q <= 1'b0;
			ofs_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end
		else if (i_clk_en)
		begin
			wr_pend_q <= wr_pend_d;
			ofs_q <= ofs_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdata_q;

	// ----------------------------------------------------------------
	// read views
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_rd = {pin, ctl_q[6:0]};
		err_rd = {err_q, 7'h00};
		if (!i_flash_enabled)
		begin
			mode_rd = 8'h00;
			err_rd = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// mode control register
	// ----------------------------------------------------------------
	always_comb
	begin
		ctl_d = ctl_q;
		ctl_d[FPEC_B_PIN] = 1'b0;
		if (wr_pend_q && (ofs_q == FPEC_OFS_MODE) && i_flash_enabled)
		begin
			ctl_d[FPEC_B_SWE] = wbyte[FPEC_B_SWE] && pin;
			ctl_d[FPEC_B_ESU] = wbyte[FPEC_B_ESU] && pin && software_enable_bit;
			ctl_d[FPEC_B_PSU] = wbyte[FPEC_B_PSU] && pin && software_enable_bit;
			ctl_d[FPEC_B_EV] = wbyte[FPEC_B_EV] && pin && software_enable_bit;
			ctl_d[FPEC_B_PV] = wbyte[FPEC_B_PV] && pin && software_enable_bit;
			ctl_d[FPEC_B_E] = wbyte[FPEC_B_E] && pin && software_enable_bit && ctl_q[FPEC_B_ESU];
			ctl_d[FPEC_B_P] = wbyte[FPEC_B_P] && pin && software_enable_bit && ctl_q[FPEC_B_PSU];
		end
		if (!pin)
		begin
			ctl_d = FPEC_RST_BYTE;
		end
		if (i_hw_standby || i_sw_standby)
		begin
			ctl_d = FPEC_RST_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// error flag
	// ----------------------------------------------------------------
	always_comb
	begin
		err_d = err_q;
		if (pe_busy)
		begin
			// array read during program or erase
			if (i_flash_read && !i_overlay_hit)
			begin
				err_d = 1'b1;
			end
			if (i_exc_start && !i_exc_exempt)
			begin
				err_d = 1'b1;
			end
			if (i_sleep_exec || i_bus_release)
			begin
				err_d = 1'b1;
			end
		end
		// cleared here by watchdog reset or hardware standby; pin reset clears it in the register
		if (i_watchdog_reset || i_hw_standby)
		begin
			err_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// erase block select
	// ----------------------------------------------------------------
	always_comb
	begin
		ebs_d = ebs_q;
		// writable only with software enable in modes 5 and 7
		if (wr_pend_q && (ofs_q == FPEC_OFS_EBS) && software_enable_bit && mode_ok && i_flash_enabled)
		begin
			ebs_d = wbyte;
		end
		if (!pin || !software_enable_bit || !mode_ok || i_hw_standby || i_sw_standby)
		begin
			ebs_d = FPEC_RST_BYTE;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctl_q <= FPEC_RST_BYTE;
			err_q <= 1'b0;
			ebs_q <= FPEC_RST_BYTE;
		end
		else if (i_clk_en)
		begin
			ctl_q <= ctl_d;
			err_q <= err_d;
			ebs_q <= ebs_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic blk_ok;
	fpec_blk_decode #(.NBLK(FPEC_NBLK)) u_dec
	(
		.i_blk_sel(ebs_q),
		.i_addr(i_flash_addr),
		.o_hit(),
		.o_erase_ok(blk_ok)
	);

	assign o_prog_active = ctl_q[FPEC_B_P] && !err_q;
	assign o_erase_active = ctl_q[FPEC_B_E] && !err_q;
	assign o_prog_verify = ctl_q[FPEC_B_PV];
	assign o_erase_verify = ctl_q[FPEC_B_EV];
	assign o_erase_addr_ok = blk_ok && ctl_q[FPEC_B_E] && !err_q;
	assign o_error_flag = err_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_swe_needs_pin: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(ctl_q[FPEC_B_SWE]) |-> $past(pin)) else $error("swe set without pin");
	a_setup_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		($rose(ctl_q[FPEC_B_ESU]) || $rose(ctl_q[FPEC_B_PSU]) || $rose(ctl_q[FPEC_B_EV])
		|| $rose(ctl_q[FPEC_B_PV])) |-> $past(software_enable_bit && pin))
		else $error("setup set without swe");
	a_erase_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(ctl_q[FPEC_B_E]) |-> $past(ctl_q[FPEC_B_ESU] && software_enable_bit && pin))
		else $error("erase set without setup");
	a_prog_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(ctl_q[FPEC_B_P]) |-> $past(ctl_q[FPEC_B_PSU] && software_enable_bit && pin))
		else $error("program set without setup");
	a_err_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(err_q && i_clk_en && !i_watchdog_reset && !i_hw_standby) |=> err_q)
		else $error("error flag lost");
	a_err_read_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_clk_en && pe_busy && i_flash_read && !i_overlay_hit && !i_hw_standby
		&& !i_watchdog_reset) |=> err_q) else $error("read did not set error");
	a_ebs_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_clk_en && !software_enable_bit) |=> (ebs_q == 8'h00)) else $error("block select not cleared");
	a_err_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		err_q |-> !o_prog_active && !o_erase_active) else $error("op while error");
endmodule : fpec_top

//--- sim/testbench.sv
// self-checking bench for the flash program/erase control block
// drives the AHB-Lite port and the control inputs itself; model in 8-bit vectors
`timescale 1ns/1ns
module testbench;
	import fpec_pkg::*;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, pin = 1, fen = 1, wdr = 0, hws = 0;
	logic frd = 0, ovl = 0, exs = 0, exx = 0, slp = 0, brl = 0, merr = 0, sws = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, mpins = 3'h5;
	logic [16:0] faddr = 0;
	logic [7:0] mm = 0, me = 0, d;
	wire hrdy, hresp, pa, ea, pvf, evf, aok, err;
	wire [31:0] hrdata;
	int n_fail = 0, tests_run = 0, cyc = 0, a;
	logic [7:0] seq [0:14] = '{8'h42, 8'h40, 8'h60, 8'h62, 8'h60, 8'h40, 8'h48, 8'h40,
		8'h44, 8'h40, 8'h41, 8'h40, 8'h50, 8'h51, 8'h51};
	// ------------------------------------------------
	// clock, timeout, design
	// ------------------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	fpec_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_write_enable_pin_level(pin), .i_mode_pins(mpins),
		.i_flash_enabled(fen), .i_hw_standby(hws), .i_sw_standby(sws),
		.i_watchdog_reset(wdr), .i_flash_read(frd), .i_overlay_hit(ovl),
		.i_flash_addr(faddr), .i_exc_start(exs), .i_exc_exempt(exx), .i_sleep_exec(slp),
		.i_bus_release(brl), .o_prog_active(pa), .o_erase_active(ea), .o_prog_verify(pvf),
		.o_erase_verify(evf), .o_erase_addr_ok(aok), .o_error_flag(err));
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// entered just after a rising edge; leaves at the edge that ends the data phase
	task xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, ad};
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h00_0000, wd};
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task wmode(input logic [7:0] wd);
		logic [7:0] n;
		n = mm & wd;
		n[6] = n[6] | (wd[6] & pin);
		n[5:2] = n[5:2] | (wd[5:2] & {4{pin & mm[6]}});
		n[1] = n[1] | (wd[1] & pin & mm[6] & mm[5]);
		n[0] = n[0] | (wd[0] & pin & mm[6] & mm[4]);
		mm = n;
		if (!n[6])
			me = 8'h00;
		xfer(1'b1, FPEC_OFS_MODE, wd);
		xfer(1'b0, FPEC_OFS_MODE, 8'h00);
		chk("mode", rd, {24'h00_0000, pin, mm[6:0]});
		#1;
		chk("verify", {30'h0, pvf, evf}, {30'h0, mm[2], mm[3]});
		chk("active", {30'h0, pa, ea}, {30'h0, mm[0] & !merr, mm[1] & !merr});
		@(posedge clk);
	endtask : wmode
	// k: 0 read, 1 exception, 2 sleep, 3 bus release, 4 watchdog, 5 hw standby
	task pulse(input int k, input logic x);
		case (k)
			0: {frd, ovl} <= {1'b1, x};
			1: {exs, exx} <= {1'b1, x};
			2: slp <= 1'b1;
			3: brl <= 1'b1;
			4: wdr <= 1'b1;
			default: hws <= 1'b1;
		endcase
		@(posedge clk);
		{frd, ovl, exs, exx, slp, brl, wdr, hws} <= 8'h00;
		if (k < 4 && !x && (mm[1] | mm[0]))
			merr = 1'b1;
		if (k > 3)
			merr = 1'b0;
		if (k == 5)
			{mm, me} = 16'h0000;
		#1;
		chk("error", {31'h0, err}, {31'h0, merr});
		chk("prog", {31'h0, pa}, {31'h0, mm[0] & !merr});
		@(posedge clk);
	endtask : pulse
	function automatic int blk(input int ad);
		if (ad < 'h1000)
			return ad / 'h400;
		if (ad < 'h8000)
			return 4;
		return 4 + ad / 'h8000;
	endfunction : blk
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		void'($urandom(72728));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		xfer(1'b0, FPEC_OFS_MODE, 8'h00);
		chk("mode_rst", rd, 32'h0000_0080);
		xfer(1'b0, FPEC_OFS_ERR, 8'h00);
		chk("err_rst", rd, 32'h0000_0000);
		xfer(1'b0, FPEC_OFS_EBS, 8'h00);
		chk("ebs_rst", rd, 32'h0000_0000);
		xfer(1'b0, 8'h0C, 8'h00);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test reset done");
		pin <= 1'b0;
		@(posedge clk);
		wmode(8'h40);
		pin <= 1'b1;
		@(posedge clk);
		wmode(8'h40);
		// mode bits tried before and after their setup bits, at most one control bit changed per write
		foreach (seq[i])
			wmode(seq[i]);
		$display("test mode sequence done");
		pulse(0, 1'b1);
		pulse(1, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			pulse(k, 1'b0);
			xfer(1'b1, FPEC_OFS_ERR, 8'h00);
			xfer(1'b0, FPEC_OFS_ERR, 8'h00);
			chk("err_ro", rd, 32'h0000_0080);
			fen <= 1'b0;
			xfer(1'b0, FPEC_OFS_ERR, 8'h00);
			chk("err_off", rd, 32'h0000_0000);
			fen <= 1'b1;
			@(posedge clk);
			pulse((k == 3) ? 5 : 4, 1'b0);
		end
		$display("test error flag done");
		wmode(8'h40);
		for (int m = 1; m < 8; m++)
		begin
			mpins <= m[2:0];
			d = $urandom;
			@(posedge clk);
			xfer(1'b1, FPEC_OFS_EBS, d);
			me = (m == 5 || m == 7) ? d : 8'h00;
			xfer(1'b0, FPEC_OFS_EBS, 8'h00);
			chk("ebs_mode", rd, {24'h00_0000, me});
		end
		mpins <= 3'h5;
		@(posedge clk);
		// one block at a time, no array access while erasing, cleared after
		for (int i = 0; i < 8; i++)
		begin
			me = 8'h01 << i;
			xfer(1'b1, FPEC_OFS_EBS, me);
			wmode(8'h60);
			wmode(8'h62);
			repeat (6)
			begin
				a = $urandom % 'h2_0000;
				if ($urandom % 2)
					a = (i < 4) ? i * 'h400 + a % 'h400 : (i == 4) ? 'h1000 + a % 'h7000 : a % 'h8000 + (i - 4) * 'h8000;
				faddr <= a[16:0];
				@(posedge clk);
				#1;
				chk("erase_ok", {31'h0, aok}, {31'h0, me[blk(a)]});
			end
			@(posedge clk);
			wmode(8'h60);
			wmode(8'h40);
		end
		wmode(8'h00);
		xfer(1'b0, FPEC_OFS_EBS, 8'h00);
		chk("ebs_swe", rd, 32'h0000_0000);
		wmode(8'h40);
		xfer(1'b1, FPEC_OFS_EBS, 8'h10);
		sws <= 1'b1;
		@(posedge clk);
		sws <= 1'b0;
		{mm, me} = 16'h0000;
		xfer(1'b0, FPEC_OFS_EBS, 8'h00);
		chk("ebs_sws", rd, 32'h0000_0000);
		xfer(1'b0, FPEC_OFS_MODE, 8'h00);
		chk("mode_sws", rd, 32'h0000_0080);
		wmode(8'h40);
		xfer(1'b1, FPEC_OFS_EBS, 8'h10);
		pin <= 1'b0;
		{mm, me} = 16'h0000;
		@(posedge clk);
		xfer(1'b0, FPEC_OFS_EBS, 8'h00);
		chk("ebs_pin", rd, 32'h0000_0000);
		$display("test erase blocks done");
		end_sim();
	end
endmodule : testbench
